// File: inc/cps_defines.svh
// register map, field positions and reset values of the clock path block
// Contract
// - bit 15 powers sensor; readback needs counter
// - bit 13 drives status pin, else tri-state
// - bit 6 picks lock detect or readback
// - three 2-bit delay range fields, one per output
// - temperature bits 11-1 read-only measurement
// - bit 0 enables counter; sensor needed too
// - function field picks buffer, divider, multiplier
// - divide by ratio+1; zero falls to buffer
// - one shared ratio field, ignored in buffer
// - bit 6 resets main clock divider
// - alignment sync in mode 0 resets divider
// - divider reset bit inert outside divider mode
// - bit 12 forces oscillator core
// - core field: start core or forced core
`ifndef CPS_DEFINES_SVH
`define CPS_DEFINES_SVH

`define CPS_IDX_SENSOR 10'h017
`define CPS_IDX_TEMP 10'h018
`define CPS_IDX_PATH 10'h019
`define CPS_IDX_CORE 10'h01c

`define CPS_RST_SENSOR 16'h4000
`define CPS_RST_TEMP 16'h0000
`define CPS_RST_PATH 16'h0211
`define CPS_RST_CORE 16'h0a08

`define CPS_WMASK_TEMP 16'h3001
`define CPS_WMASK_CORE 16'h1fff

`define CPS_B_TS_ON 15
`define CPS_B_DRIVE 13
`define CPS_B_SRC 6
`define CPS_F_LRANGE 5:4
`define CPS_F_A3RANGE 3:2
`define CPS_F_A2RANGE 1:0
`define CPS_F_TRES 11:1
`define CPS_B_CNT_ON 0
`define CPS_F_FUNC 2:0
`define CPS_F_RATIO 5:3
`define CPS_B_DIVRST 6
`define CPS_B_FORCE 12
`define CPS_F_CORE 11:9

`define CPS_FN_BUF 3'h1
`define CPS_FN_DIV 3'h2
`define CPS_FN_MUL 3'h3
`define CPS_RATIO_OFF 3'h0
`define CPS_MUL_MAX 3'h4
`define CPS_REQ_MODE_DIV 2'h0

`endif

// File: inc/cps_pkg.sv
// types shared by the clock path block
package cps_pkg;

    typedef enum logic [1:0] {
        CPS_RSVD = 2'b00,
        CPS_BUF = 2'b01,
        CPS_DIV = 2'b10,
        CPS_MUL = 2'b11
    } cps_mode_e;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } cps_apb_req_s;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } cps_apb_rsp_s;

    typedef struct packed {
        cps_mode_e mode;
        logic [3:0] divide_by;
        logic [2:0] mult_by;
    } cps_path_s;

    typedef struct packed {
        logic [1:0] logic_align_delay_range;
        logic [1:0] align3_delay_range;
        logic [1:0] align2_delay_range;
    } cps_ranges_s;

endpackage

// File: sim/cps_regs_properties.sv
// concurrent checks on the ports of the clock path register bank
`timescale 1ns/1ps
module cps_regs_properties #(
    parameter int REQ_MODE_W = 2
) (
    // clock, reset, enable
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    // apb
    input wire cps_pkg::cps_apb_req_s apb_req,
    input wire cps_pkg::cps_apb_rsp_s apb_rsp,
    // sensor and status pin
    input wire logic [10:0] temp_code,
    input wire logic temp_done,
    input wire logic temp_sensor_on,
    input wire logic temp_counter_on,
    input wire logic lock_detect_pin,
    input wire logic readback_bit,
    input wire logic status_out_pin_o,
    input wire logic status_out_pin_oe_n,
    // ranges, alignment, path, core
    input wire cps_pkg::cps_ranges_s delay_ranges,
    input wire logic align_request_pins,
    input wire logic [REQ_MODE_W-1:0] align_request_mode,
    input wire logic sync_en,
    input wire cps_pkg::cps_path_s clock_path,
    input wire logic divider_reset,
    input wire logic osc_core_force,
    input wire logic [2:0] osc_core_select
);
    logic wr;
    logic [2:0] fn;
    logic [2:0] ra;
    assign wr = apb_req.psel && apb_req.penable && apb_rsp.pready && apb_req.pwrite && clk_en;
    assign fn = apb_req.pwdata[2:0];
    assign ra = apb_req.pwdata[5:3];

    default clocking dc @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    AST_SENSOR_ON: assert property (wr && apb_req.paddr == 12'h05c |=>
        temp_sensor_on == $past(apb_req.pwdata[15])) else $error("sensor enable wrong");
    AST_DRIVE: assert property (wr && apb_req.paddr == 12'h05c |=>
        status_out_pin_oe_n == !$past(apb_req.pwdata[13])) else $error("pin drive wrong");
    AST_RANGES: assert property (wr && apb_req.paddr == 12'h05c |=>
        delay_ranges == $past(apb_req.pwdata[5:0])) else $error("delay ranges wrong");
    AST_COUNTER_ON: assert property (wr && apb_req.paddr == 12'h060 |=>
        temp_counter_on == $past(apb_req.pwdata[0])) else $error("counter enable wrong");
    AST_DIVIDE: assert property (wr && apb_req.paddr == 12'h064 && fn == 3'h2 && ra != 3'h0 |=>
        clock_path.mode == cps_pkg::CPS_DIV
        && clock_path.divide_by == {1'b0, $past(ra)} + 4'h1) else $error("divider wrong");
    AST_MULTIPLY: assert property (wr && apb_req.paddr == 12'h064 && fn == 3'h3
        && ra inside {[3'h1:3'h4]} |=> clock_path.mode == cps_pkg::CPS_MUL
        && clock_path.mult_by == $past(ra)) else $error("multiplier wrong");
    AST_DIV_RESET: assert property (wr && apb_req.paddr == 12'h064 && fn == 3'h2
        && ra != 3'h0 && apb_req.pwdata[6] |=> divider_reset) else $error("no divider reset");
    AST_DIV_RESET_INERT: assert property (wr && apb_req.paddr == 12'h064 && fn != 3'h2
        && !sync_en |-> ##2 !divider_reset ##1 !divider_reset) else $error("stray divider reset");
    AST_CORE: assert property (wr && apb_req.paddr == 12'h070 |=>
        osc_core_force == $past(apb_req.pwdata[12])
        && osc_core_select == $past(apb_req.pwdata[11:9])) else $error("core select wrong");

    cover property (wr && apb_req.paddr == 12'h064);
    cover property (divider_reset);
    cover property (apb_rsp.pslverr);
endmodule

bind cps_regs cps_regs_properties #(.REQ_MODE_W(REQ_MODE_W)) u_props (
    .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .apb_req(apb_req), .apb_rsp(apb_rsp),
    .temp_code(temp_code), .temp_done(temp_done), .temp_sensor_on(temp_sensor_on),
    .temp_counter_on(temp_counter_on), .lock_detect_pin(lock_detect_pin),
    .readback_bit(readback_bit), .status_out_pin_o(status_out_pin_o),
    .status_out_pin_oe_n(status_out_pin_oe_n), .delay_ranges(delay_ranges),
    .align_request_pins(align_request_pins), .align_request_mode(align_request_mode),
    .sync_en(sync_en), .clock_path(clock_path), .divider_reset(divider_reset),
    .osc_core_force(osc_core_force), .osc_core_select(osc_core_select)
);

// File: sim/cps_regs_tb.sv
// self-checking bench for the clock path register bank
`timescale 1ns/1ps
module cps_regs_tb;
    typedef struct packed { logic [11:0] a; logic [15:0] d; logic e; logic [15:0] x; } cps_row_s;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    cps_pkg::cps_apb_req_s req = '0;
    cps_pkg::cps_apb_rsp_s rsp;
    logic [10:0] temp_code = 11'h000;
    logic temp_done = 1'b0;
    logic lock_pin = 1'b0;
    logic rb_bit = 1'b0;
    logic align_pin = 1'b0;
    logic [1:0] req_mode = 2'h0;
    logic sync_en = 1'b0;
    logic ce = 1'b1;
    logic ts_on, cnt_on, pin_o, oe_n, div_rst, force_on, hit, err;
    logic [2:0] core;
    logic [31:0] rd;
    cps_pkg::cps_ranges_s ranges;
    cps_pkg::cps_path_s path;
    cps_pkg::cps_mode_e em;
    int err_total = 0;
    int total_checks = 0;
    int cyc = 0;
    // reset reads first, then writes; 0x68 is unmapped
    cps_row_s rows [12] = '{'{12'h05c, 0, 0, 16'h4000}, '{12'h060, 0, 0, 16'h0000},
        '{12'h064, 0, 0, 16'h0211}, '{12'h070, 0, 0, 16'h0a08}, '{12'h05c, 16'hffff, 0, 16'hffff},
        '{12'h05c, 16'h4000, 0, 16'h4000}, '{12'h060, 16'hffff, 0, 16'h3001},
        '{12'h060, 16'h0000, 0, 16'h0000}, '{12'h070, 16'hffff, 0, 16'h1fff},
        '{12'h070, 16'h0a08, 0, 16'h0a08}, '{12'h064, 16'hffff, 0, 16'hffff},
        '{12'h068, 16'hffff, 1, 16'h0000}};

    cps_regs dut (
        .pclk(pclk), .presetn(presetn), .clk_en(ce), .apb_req(req), .apb_rsp(rsp),
        .temp_code(temp_code), .temp_done(temp_done), .temp_sensor_on(ts_on),
        .temp_counter_on(cnt_on), .lock_detect_pin(lock_pin), .readback_bit(rb_bit),
        .status_out_pin_o(pin_o), .status_out_pin_oe_n(oe_n), .delay_ranges(ranges),
        .align_request_pins(align_pin), .align_request_mode(req_mode), .sync_en(sync_en),
        .clock_path(path), .divider_reset(div_rst), .osc_core_force(force_on),
        .osc_core_select(core)
    );

    always #12.5 pclk = ~pclk;

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic stop_test();
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // one apb transfer; waits for pready with no limit of its own
    task automatic apb(input logic w, input logic [11:0] a, input logic [15:0] d);
        @(posedge pclk);
        req <= '{1'b1, 1'b0, w, a, {16'h0000, d}};
        @(posedge pclk);
        req.penable <= 1'b1;
        // no wait limit here: the bench timeout ends a hung transfer
        do
        begin
            @(posedge pclk);
        end
        while (rsp.pready !== 1'b1);
        rd = rsp.prdata;
        err = rsp.pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
    endtask

    task automatic pulse(input logic [10:0] c);
        @(posedge pclk);
        temp_code <= c;
        temp_done <= 1'b1;
        @(posedge pclk);
        temp_done <= 1'b0;
    endtask

    always @(posedge pclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            err_total++;
            stop_test();
        end
    end

    initial
    begin
        repeat (20) @(posedge pclk);
        chk({oe_n, pin_o, core, path.mode}, {1'b1, 1'b0, 3'h5, 2'b01});
        presetn <= 1'b1;
        foreach (rows[i])
        begin
            if (i >= 4)
                apb(1'b1, rows[i].a, rows[i].d);
            apb(1'b0, rows[i].a, 16'h0000);
            chk({err, rd[30:0]}, {rows[i].e, 15'h0000, rows[i].x});
        end
        chk({force_on, core}, {1'b0, 3'h5});
        for (int f = 0; f < 8; f++)
            for (int r = 0; r < 8; r++)
            begin
                apb(1'b1, 12'h064, {9'h004, 1'b0, r[2:0], f[2:0]});
                @(posedge pclk);
                em = (f == 1 || (f == 2 && r == 0) || (f == 3 && (r == 0 || r > 4))) ?
                    cps_pkg::CPS_BUF : (f == 2) ? cps_pkg::CPS_DIV :
                    (f == 3) ? cps_pkg::CPS_MUL : cps_pkg::CPS_RSVD;
                chk(path.mode, em);
                if (em == cps_pkg::CPS_DIV)
                    chk(path.divide_by, r[3:0] + 4'h1);
                if (em == cps_pkg::CPS_MUL)
                    chk(path.mult_by, r[2:0]);
            end
        apb(1'b1, 12'h064, 16'h0252);
        repeat (2) @(posedge pclk);
        chk(div_rst, 1'b1);
        apb(1'b1, 12'h064, 16'h0251);
        repeat (2) @(posedge pclk);
        chk(div_rst, 1'b0);
        apb(1'b1, 12'h064, 16'h0212);
        repeat (2) @(posedge pclk);
        sync_en <= 1'b1;
        req_mode <= 2'h1;
        align_pin <= 1'b1;
        hit = 1'b0;
        repeat (10)
        begin
            @(posedge pclk);
            hit = hit | div_rst;
        end
        chk(hit, 1'b0);
        align_pin <= 1'b0;
        req_mode <= 2'h0;
        repeat (8) @(posedge pclk);
        align_pin <= 1'b1;
        for (int n = 0; n < 10 && div_rst !== 1'b1; n++)
            @(posedge pclk);
        chk(div_rst, 1'b1);
        @(posedge pclk);
        chk(div_rst, 1'b0);
        sync_en <= 1'b0;
        apb(1'b1, 12'h05c, 16'h6040);
        rb_bit <= 1'b1;
        repeat (3) @(posedge pclk);
        chk({oe_n, pin_o}, 2'b01);
        apb(1'b1, 12'h05c, 16'h6000);
        lock_pin <= 1'b1;
        repeat (8) @(posedge pclk);
        chk({oe_n, pin_o}, 2'b01);
        lock_pin <= 1'b0;
        repeat (8) @(posedge pclk);
        chk(pin_o, 1'b0);
        // enable low freezes synchronisers and the pin register
        ce <= 1'b0;
        lock_pin <= 1'b1;
        repeat (8) @(posedge pclk);
        chk(pin_o, 1'b0);
        ce <= 1'b1;
        repeat (8) @(posedge pclk);
        chk(pin_o, 1'b1);
        lock_pin <= 1'b0;
        apb(1'b1, 12'h05c, 16'h4026);
        @(posedge pclk);
        chk({oe_n, ranges}, {1'b1, 6'h26});
        apb(1'b1, 12'h05c, 16'hc000);
        apb(1'b1, 12'h060, 16'h0001);
        pulse(11'h5a5);
        chk({ts_on, cnt_on}, 2'b11);
        apb(1'b0, 12'h060, 16'h0000);
        chk(rd, 32'h00000b4b);
        // counter off keeps the last result
        apb(1'b1, 12'h060, 16'hfffe);
        pulse(11'h123);
        apb(1'b0, 12'h060, 16'h0000);
        chk(rd, 32'h00003b4a);
        apb(1'b1, 12'h05c, 16'h4000);
        apb(1'b1, 12'h060, 16'h0001);
        pulse(11'h0f0);
        apb(1'b0, 12'h060, 16'h0000);
        chk(rd, 32'h00000b4b);
        // second reset in mid-run drops counter enable and result
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        chk({oe_n, ts_on, cnt_on, div_rst, path.mode, core}, {1'b1, 3'h0, 2'b01, 3'h5});
        presetn <= 1'b1;
        apb(1'b0, 12'h060, 16'h0000);
        chk(rd, 32'h00000000);
        stop_test();
    end
endmodule

// File: verilog/cps_path_decode.sv
// resolves function and ratio fields into the effective clock path
`timescale 1ns/1ps
`include "cps_defines.svh"
module cps_path_decode (
    // register fields
    input wire logic [2:0] path_function,
    input wire logic [2:0] ratio,
    // resolved path
    output cps_pkg::cps_path_s path
);

    always_comb
    begin
        path.mode = cps_pkg::CPS_RSVD;
        path.divide_by = 4'h1;
        path.mult_by = 3'h1;
        unique case (path_function)
            `CPS_FN_BUF:
            begin
                path.mode = cps_pkg::CPS_BUF;
            end
            `CPS_FN_DIV:
            begin
                if (ratio != `CPS_RATIO_OFF)
                begin
                    path.mode = cps_pkg::CPS_DIV;
                    path.divide_by = {1'b0, ratio} + 4'h1;
                end
                else
                begin
                    path.mode = cps_pkg::CPS_BUF;
                end
            end
            `CPS_FN_MUL:
            begin
                if (ratio != `CPS_RATIO_OFF && ratio <= `CPS_MUL_MAX)
                begin
                    path.mode = cps_pkg::CPS_MUL;
                    path.mult_by = ratio;
                end
                else
                begin
                    path.mode = cps_pkg::CPS_BUF;
                end
            end
            default:
            begin
                // code 0 and unused codes leave the path reserved
                path.mode = cps_pkg::CPS_RSVD;
            end
        endcase
    end

endmodule

// File: verilog/cps_pin_sync.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module cps_pin_sync (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    // pin and clean level
    input wire logic pin_in,
    output logic level
);

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic level;
    } cps_sync_s;

    cps_sync_s st_q;
    cps_sync_s st_d;

    always_comb
    begin
        st_d = st_q;
        st_d.s1 = pin_in;
        st_d.s2 = st_q.s1;
        st_d.s3 = st_q.s2;
        // first stage is never looked at by the filter
        if (st_q.s2 == st_q.s3)
        begin
            st_d.level = st_q.s3;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_q <= '0;
        end
        else if (clk_en)
        begin
            st_q <= st_d;
        end
    end

    assign level = st_q.level;

endmodule

// File: verilog/cps_regs.sv
// apb register bank for sensor, status pin, delay ranges and clock path
`timescale 1ns/1ps
`include "cps_defines.svh"
module cps_regs #(
    parameter int REQ_MODE_W = 2
) (
    // clock, reset, enable
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    // apb
    input wire cps_pkg::cps_apb_req_s apb_req,
    output cps_pkg::cps_apb_rsp_s apb_rsp,
    // temperature sensor
    input wire logic [10:0] temp_code,
    input wire logic temp_done,
    output logic temp_sensor_on,
    output logic temp_counter_on,
    // status pin
    input wire logic lock_detect_pin,
    input wire logic readback_bit,
    output logic status_out_pin_o,
    output logic status_out_pin_oe_n,
    // alignment delay ranges
    output cps_pkg::cps_ranges_s delay_ranges,
    // alignment request
    input wire logic align_request_pins,
    input wire logic [REQ_MODE_W-1:0] align_request_mode,
    input wire logic sync_en,
    // main clock path
    output cps_pkg::cps_path_s clock_path,
    output logic divider_reset,
    // oscillator core
    output logic osc_core_force,
    output logic [2:0] osc_core_select
);

    typedef struct packed {
        logic [15:0] sensor_cfg;
        logic [15:0] temp_res;
        logic [15:0] path_cfg;
        logic [15:0] core_cfg;
        cps_pkg::cps_apb_rsp_s rsp;
        logic sensor_on;
        logic counter_on;
        logic pin_out;
        logic pin_oe_n;
        cps_pkg::cps_ranges_s ranges;
        cps_pkg::cps_path_s path;
        logic div_rst;
        logic force_core;
        logic [2:0] core_sel;
        logic align_prev;
    } cps_state_s;

    cps_state_s st_q;
    cps_state_s st_d;

    logic lock_level;
    logic align_level;
    cps_pkg::cps_path_s path_now;

    // byte address of a register from its printed index
    function automatic logic hit(input logic [11:0] addr, input logic [9:0] idx);
        hit = (addr == {idx, 2'b00});
    endfunction

    // keep read-only bits, take only writable ones from the bus
    function automatic logic [15:0] merge(
        input logic [15:0] old,
        input logic [15:0] wdat,
        input logic [15:0] wmask
    );
        merge = (old & ~wmask) | (wdat & wmask);
    endfunction

    cps_pin_sync u_lock_sync (
        .pclk(pclk),
        .presetn(presetn),
        .clk_en(clk_en),
        .pin_in(lock_detect_pin),
        .level(lock_level)
    );

    cps_pin_sync u_align_sync (
        .pclk(pclk),
        .presetn(presetn),
        .clk_en(clk_en),
        .pin_in(align_request_pins),
        .level(align_level)
    );

    // decode from the next value so outputs track a write in one cycle
    cps_path_decode u_decode (
        .path_function(st_d.path_cfg[`CPS_F_FUNC]),
        .ratio(st_d.path_cfg[`CPS_F_RATIO]),
        .path(path_now)
    );

    logic setup;
    logic access;
    logic mapped;
    logic [15:0] wdat;
    logic [15:0] rdat;
    logic sync_evt;

    always_comb
    begin
        setup = apb_req.psel && !apb_req.penable;
        access = apb_req.psel && apb_req.penable;
        mapped = hit(apb_req.paddr, `CPS_IDX_SENSOR)
            || hit(apb_req.paddr, `CPS_IDX_TEMP)
            || hit(apb_req.paddr, `CPS_IDX_PATH)
            || hit(apb_req.paddr, `CPS_IDX_CORE);
        wdat = apb_req.pwdata[15:0];
        rdat = 16'h0000;
        if (hit(apb_req.paddr, `CPS_IDX_SENSOR))
        begin
            rdat = st_q.sensor_cfg;
        end
        else if (hit(apb_req.paddr, `CPS_IDX_TEMP))
        begin
            rdat = st_q.temp_res & (`CPS_WMASK_TEMP | 16'h0ffe);
        end
        else if (hit(apb_req.paddr, `CPS_IDX_PATH))
        begin
            rdat = st_q.path_cfg;
        end
        else if (hit(apb_req.paddr, `CPS_IDX_CORE))
        begin
            rdat = st_q.core_cfg & `CPS_WMASK_CORE;
        end
        sync_evt = align_level && !st_q.align_prev;
    end

    always_comb
    begin
        st_d = st_q;
        st_d.align_prev = align_level;

        // no wait state: answer is prepared in the setup cycle
        st_d.rsp.pready = 1'b0;
        st_d.rsp.pslverr = 1'b0;
        if (setup)
        begin
            st_d.rsp.pready = 1'b1;
            st_d.rsp.pslverr = !mapped;
            st_d.rsp.prdata = {16'h0000, rdat};
            if (apb_req.pwrite || !mapped)
            begin
                st_d.rsp.prdata = 32'h0000_0000;
            end
        end

        // a write lands only at the completing access edge
        if (access && st_q.rsp.pready && apb_req.pwrite)
        begin
            if (hit(apb_req.paddr, `CPS_IDX_SENSOR))
            begin
                // undisclosed bits stored as written, software owns them
                st_d.sensor_cfg = wdat;
            end
            if (hit(apb_req.paddr, `CPS_IDX_TEMP))
            begin
                st_d.temp_res = merge(st_q.temp_res, wdat, `CPS_WMASK_TEMP);
            end
            if (hit(apb_req.paddr, `CPS_IDX_PATH))
            begin
                st_d.path_cfg = wdat;
            end
            if (hit(apb_req.paddr, `CPS_IDX_CORE))
            begin
                st_d.core_cfg = merge(st_q.core_cfg, wdat, `CPS_WMASK_CORE);
            end
        end

        // measurement is captured only with sensor and counter both on
        if (temp_done && st_q.sensor_on && st_q.counter_on)
        begin
            st_d.temp_res[`CPS_F_TRES] = temp_code;
        end

        st_d.sensor_on = st_d.sensor_cfg[`CPS_B_TS_ON];
        st_d.counter_on = st_d.temp_res[`CPS_B_CNT_ON];

        // pin source and drive
        st_d.pin_oe_n = !st_d.sensor_cfg[`CPS_B_DRIVE];
        if (st_d.sensor_cfg[`CPS_B_SRC])
        begin
            st_d.pin_out = readback_bit;
        end
        else
        begin
            st_d.pin_out = lock_level;
        end

        st_d.ranges.logic_align_delay_range = st_d.sensor_cfg[`CPS_F_LRANGE];
        st_d.ranges.align3_delay_range = st_d.sensor_cfg[`CPS_F_A3RANGE];
        st_d.ranges.align2_delay_range = st_d.sensor_cfg[`CPS_F_A2RANGE];

        st_d.path = path_now;

        // reset bit is gated by divider mode; sync request acts alone
        st_d.div_rst = 1'b0;
        if (st_d.path_cfg[`CPS_B_DIVRST] && path_now.mode == cps_pkg::CPS_DIV)
        begin
            st_d.div_rst = 1'b1;
        end
        if (sync_evt && sync_en
            && align_request_mode == REQ_MODE_W'(`CPS_REQ_MODE_DIV))
        begin
            st_d.div_rst = 1'b1;
        end

        st_d.force_core = st_d.core_cfg[`CPS_B_FORCE];
        st_d.core_sel = st_d.core_cfg[`CPS_F_CORE];
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_q.sensor_cfg <= `CPS_RST_SENSOR;
            st_q.temp_res <= `CPS_RST_TEMP;
            st_q.path_cfg <= `CPS_RST_PATH;
            st_q.core_cfg <= `CPS_RST_CORE;
            st_q.rsp <= '0;
            st_q.sensor_on <= 1'b0;
            st_q.counter_on <= 1'b0;
            st_q.pin_out <= 1'b0;
            st_q.pin_oe_n <= 1'b1;
            st_q.ranges <= '0;
            st_q.path <= {cps_pkg::CPS_BUF, 4'h1, 3'h1};
            st_q.div_rst <= 1'b0;
            st_q.force_core <= 1'b0;
            st_q.core_sel <= 3'h5;
            st_q.align_prev <= 1'b0;
        end
        else if (clk_en)
        begin
            st_q <= st_d;
        end
    end

    assign apb_rsp = st_q.rsp;
    assign temp_sensor_on = st_q.sensor_on;
    assign temp_counter_on = st_q.counter_on;
    assign status_out_pin_o = st_q.pin_out;
    assign status_out_pin_oe_n = st_q.pin_oe_n;
    assign delay_ranges = st_q.ranges;
    assign clock_path = st_q.path;
    assign divider_reset = st_q.div_rst;
    assign osc_core_force = st_q.force_core;
    assign osc_core_select = st_q.core_sel;

endmodule
